/* hw/dcs_pkg.sv */
// constants, encodings and decode functions of the debug command/status block
package dcs_pkg;

   // ------------------------------------------------------------------
   // start-up timing
   // ------------------------------------------------------------------
   localparam int unsigned READY_CYC       = 10;
   localparam int unsigned MODE_SAMPLE_CYC = 3;

   // ------------------------------------------------------------------
   // pin signalling, in core clock cycles
   // ------------------------------------------------------------------
   localparam int unsigned TX_BIT_CYC      = 16;
   localparam int unsigned TX_ZERO_LOW_CYC = 13;
   localparam int unsigned TX_ONE_LOW_CYC  = 4;
   localparam int unsigned SPEEDUP_CYC     = 1;

   // ------------------------------------------------------------------
   // command opcodes
   // ------------------------------------------------------------------
   localparam logic [7:0] OP_READ_STATUS  = 8'h2d;
   localparam logic [7:0] OP_WRITE_STATUS = 8'h0d;
   localparam logic [7:0] OP_ERASE_FLASH  = 8'h95;
   localparam logic [7:0] OP_BACKGROUND   = 8'h04;
   localparam logic [7:0] OP_GO           = 8'h08;
   localparam logic [7:0] OP_SINGLE_STEP_COMMAND        = 8'h0a;
   localparam logic [7:0] OP_READ_MEM     = 8'h30;
   localparam logic [7:0] OP_DUMP_MEM     = 8'h32;
   localparam logic [7:0] OP_READ_SAME    = 8'h54;
   localparam logic [7:0] OP_WRITE_MEM    = 8'h10;
   localparam logic [7:0] OP_FILL_MEM     = 8'h12;
   localparam logic [7:0] OP_WS_MASK      = 8'h01;

   // ------------------------------------------------------------------
   // status register layout and reset values
   // ------------------------------------------------------------------
   localparam int unsigned HI_ILLEGAL = 0;
   localparam int unsigned HI_NO_RESPONSE_FLAG  = 1;
   localparam int unsigned HI_WAIT    = 2;
   localparam int unsigned HI_UNSECURED_FLAG   = 3;
   localparam int unsigned HI_ERASE   = 4;
   localparam int unsigned HI_HALTED  = 5;
   localparam int unsigned LO_ENABLE  = 7;
   localparam logic [7:0]  STATUS_RST = 8'h00;
   localparam logic [7:0]  FILL_BYTE  = 8'hee;

   // ------------------------------------------------------------------
   // state encodings
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      MS_NONE  = 3'b001,
      MS_READ  = 3'b010,
      MS_WRITE = 3'b100
   } dcs_mseq_type;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_LOW  = 3'b010,
      TX_HIGH = 3'b100
   } dcs_tx_type;

   // ------------------------------------------------------------------
   // opcode decoding
   // ------------------------------------------------------------------
   function automatic logic [7:0] dcs_base(input logic [7:0] op);
      dcs_base = op & ~OP_WS_MASK;
   endfunction

   function automatic logic dcs_is_mem(input logic [7:0] op);
      logic [7:0] b;
      b = dcs_base(op);
      dcs_is_mem = (b == OP_READ_MEM) || (b == OP_DUMP_MEM) ||
                   (b == OP_READ_SAME) || (b == OP_WRITE_MEM) ||
                   (b == OP_FILL_MEM);
   endfunction

   function automatic logic dcs_is_always(input logic [7:0] op);
      dcs_is_always = (op == OP_READ_STATUS) || (op == OP_WRITE_STATUS) ||
                      (op == OP_ERASE_FLASH);
   endfunction

   function automatic logic dcs_is_known(input logic [7:0] op);
      dcs_is_known = dcs_is_always(op) || dcs_is_mem(op) ||
                     (op == OP_BACKGROUND) || (op == OP_GO) ||
                     (op == OP_SINGLE_STEP_COMMAND);
   endfunction

   function automatic logic dcs_is_active(input logic [7:0] op);
      dcs_is_active = dcs_is_mem(op) || (op == OP_GO) || (op == OP_SINGLE_STEP_COMMAND);
   endfunction

   function automatic logic dcs_is_read(input logic [7:0] op);
      logic [7:0] b;
      b = dcs_base(op);
      dcs_is_read = dcs_is_mem(op) && ((b == OP_READ_MEM) ||
                    (b == OP_DUMP_MEM) || (b == OP_READ_SAME));
   endfunction

   function automatic logic [2:0] dcs_nbytes(input logic [2:0] size);
      dcs_nbytes = ((size == 3'h0) || (size > 3'h4)) ? 3'h4 : size;
   endfunction

endpackage

/* hw/dcs_sync.sv */
// two-stage synchroniser for the debug wire pin
`timescale 1ns/100ps
module dcs_sync (
   input  wire logic sys_clk_i,
   input  wire logic arst_n_i,
   input  wire logic async_i,
   output logic      sync_o
);

   logic meta_q;

   // pin idles high through its pull-up
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_q <= 1'b1;
         sync_o <= 1'b1;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end

endmodule

/* hw/dcs_pin_drv.sv */
// pseudo-open-drain driver with a speed-up pulse after each low phase
`timescale 1ns/100ps
module dcs_pin_drv #(
   parameter int unsigned SPEEDUP = dcs_pkg::SPEEDUP_CYC
) (
   input  wire logic sys_clk_i,
   input  wire logic arst_n_i,
   input  wire logic pull_low_i,
   output logic      pin_o,
   output logic      pin_oe_o
);
   import dcs_pkg::*;

   localparam logic [3:0] SPEEDUP_CNT = 4'(SPEEDUP);

   logic [3:0] spd_cnt_q;
   logic [3:0] spd_cnt_d;
   logic       low_q;
   logic       rise_w;

   // high drive only right after our own low, so no party fights it
   assign rise_w    = low_q && !pull_low_i;
   assign spd_cnt_d = rise_w ? SPEEDUP_CNT :
                      (spd_cnt_q != 4'h0) ? spd_cnt_q - 4'h1 : 4'h0;

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         low_q     <= 1'b0;
         spd_cnt_q <= 4'h0;
         pin_o     <= 1'b1;
         pin_oe_o  <= 1'b0;
      end else begin
         low_q     <= pull_low_i;
         spd_cnt_q <= spd_cnt_d;
         pin_o     <= !pull_low_i;
         pin_oe_o  <= pull_low_i || (spd_cnt_d != 4'h0);
      end
   end

endmodule

/* hw/dcs_debug_ctrl.sv */
// command check, status flags and security gating of the debug controller
`timescale 1ns/100ps

// Function
// - a step into the wait instruction completes only after wait is left.
// - the first step into wait mode sets the wait-entered flag.
// - a further step while still waiting sets no-response and illegal flags.
// - pin is mode select during reset, serial line only afterwards.
// - pin is pulled low or given short high speed-up pulses, no conflicts.
// - the two status bytes are reached only by the status commands.
// - an unimplemented opcode sets the illegal-command flag in bit 0.
// - dump, fill or reread out of sequence sets the illegal-command flag.
// - a halted-mode command while not halted sets the illegal-command flag.
// - non always-available command while disabled or erasing is illegal.
// - non always-available command while secured is illegal.
// - a rejected read returns 0xEE for every data byte.
// - writing one clears the illegal-command flag, zero leaves it.
// - coming out of reset secured clears the unsecured flag.
// - while secured only the status register and erase are reachable.
// - a good mass erase programs security open and sets the unsecured flag.
// - a failed mass erase leaves the part secured and the flag clear.
// - halted mode needs the enable bit set by the write-status command.
// - the first command is taken ten cycles after reset release.
module dcs_debug_ctrl #(
   parameter int unsigned BIT_CYC  = dcs_pkg::TX_BIT_CYC,
   parameter int unsigned ZERO_LOW = dcs_pkg::TX_ZERO_LOW_CYC,
   parameter int unsigned ONE_LOW  = dcs_pkg::TX_ONE_LOW_CYC
) (
   input  wire logic        sys_clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        dbg_wire_pin_i,
   output logic             dbg_wire_pin_o,
   output logic             dbg_wire_pin_oe_o,
   input  wire logic        cmd_valid_i,
   input  wire logic [7:0]  cmd_opcode_i,
   input  wire logic [15:0] cmd_wdata_i,
   input  wire logic [2:0]  cmd_size_i,
   input  wire logic        mem_rvalid_i,
   input  wire logic [31:0] mem_rdata_i,
   input  wire logic        cpu_bgnd_i,
   input  wire logic        cpu_wait_i,
   input  wire logic        cpu_step_done_i,
   input  wire logic        secure_i,
   input  wire logic        erase_done_i,
   input  wire logic        erase_ok_i,
   output logic             ready_o,
   output logic             mode_select_o,
   output logic             dbg_rx_o,
   output logic             tx_busy_o,
   output logic             cmd_exec_o,
   output logic [7:0]       cmd_exec_op_o,
   output logic             cpu_halt_o,
   output logic             cpu_go_o,
   output logic             cpu_step_o,
   output logic             erase_req_o,
   output logic             program_unsecured_flag_o,
   output logic [7:0]       status_hi_o,
   output logic [7:0]       status_lo_o
);
   import dcs_pkg::*;

   // ------------------------------------------------------------------
   // constants sized to their targets
   // ------------------------------------------------------------------
   localparam logic [3:0] READY_CNT  = 4'(READY_CYC - 1);
   localparam logic [3:0] SAMPLE_CNT = 4'(MODE_SAMPLE_CYC);
   localparam logic [7:0] BIT_CNT    = 8'(BIT_CYC);
   localparam logic [7:0] ZERO_CNT   = 8'(ZERO_LOW);
   localparam logic [7:0] ONE_CNT    = 8'(ONE_LOW);

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   logic         pin_sync_w, ready_q, start_w, busy_q, step_pend_q;
   logic         ill_q, no_response_flag_q, wait_q, unsecured_flag_q, enable_q, halted_q;
   logic         cpu_wait_q, rd_wait_q, acc_w, known_w, always_w, active_w;
   logic         read_w, seq_bad_w, gate_bad_w, step_wait_w, ill_w, legal_w;
   logic         wr_stat_w, rd_stat_w, is_step_w, is_go_w, is_bg_w, erase_w;
   logic         mem_w, wait_rise_w, step_fin_w, erase_good_w, ld_stat_w;
   logic         ld_fill_w, ld_mem_w, tx_load_w, bit_end_w;
   logic [2:0]   rd_size_q, ld_n_w;
   logic [3:0]   rdy_cnt_q;
   logic [5:0]   tx_bits_q;
   logic [7:0]   tx_cnt_q, op_w, low_cnt_w, hi_w, lo_w;
   logic [31:0]  tx_sh_q, ld_data_w;
   dcs_mseq_type mseq_q, mseq_d;
   dcs_tx_type   tx_q, tx_d;

   // ------------------------------------------------------------------
   // pin input and start-up
   // ------------------------------------------------------------------
   dcs_sync u_sync (
      .sys_clk_i (sys_clk_i),
      .arst_n_i  (arst_n_i),
      .async_i   (dbg_wire_pin_i),
      .sync_o    (pin_sync_w)
   );

   assign start_w = !ready_q && (rdy_cnt_q == READY_CNT);

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdy_cnt_q     <= 4'h0;
         ready_q       <= 1'b0;
         mode_select_o <= 1'b1;
         dbg_rx_o      <= 1'b1;
      end else begin
         if (!ready_q) begin
            rdy_cnt_q <= rdy_cnt_q + 4'h1;
         end
         if (start_w) begin
            ready_q <= 1'b1;
         end
         if (!ready_q && (rdy_cnt_q == SAMPLE_CNT)) begin
            mode_select_o <= pin_sync_w;
         end
         dbg_rx_o <= ready_q ? pin_sync_w : 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // command checking
   // ------------------------------------------------------------------
   assign op_w     = cmd_opcode_i;
   assign acc_w    = cmd_valid_i && ready_q && (tx_q == TX_IDLE) &&
                     !rd_wait_q;
   assign known_w  = dcs_is_known(op_w);
   assign always_w = dcs_is_always(op_w);
   assign active_w = dcs_is_active(op_w);
   assign read_w   = dcs_is_read(op_w);

   assign seq_bad_w =
      ((dcs_base(op_w) == OP_DUMP_MEM) && (mseq_q != MS_READ)) ||
      ((dcs_base(op_w) == OP_READ_SAME) && (mseq_q != MS_READ)) ||
      ((dcs_base(op_w) == OP_FILL_MEM) && (mseq_q != MS_WRITE));

   assign gate_bad_w = !always_w &&
      (!enable_q || busy_q || !unsecured_flag_q);

   assign step_wait_w = acc_w && (op_w == OP_SINGLE_STEP_COMMAND) && step_pend_q &&
                        cpu_wait_i;

   // one flag for any mix of causes
   assign ill_w = acc_w && (!known_w || gate_bad_w ||
                  (active_w && !halted_q) ||
                  seq_bad_w);

   assign legal_w   = acc_w && !ill_w;
   assign wr_stat_w = legal_w && (op_w == OP_WRITE_STATUS);
   assign rd_stat_w = legal_w && (op_w == OP_READ_STATUS);
   assign is_step_w = legal_w && (op_w == OP_SINGLE_STEP_COMMAND);
   assign is_go_w   = legal_w && (op_w == OP_GO);
   assign is_bg_w   = legal_w && (op_w == OP_BACKGROUND);
   assign erase_w   = legal_w && (op_w == OP_ERASE_FLASH) && !busy_q;
   assign mem_w     = legal_w && dcs_is_mem(op_w);

   assign mseq_d = !acc_w ? mseq_q :
                   !mem_w ? MS_NONE :
                   read_w ? MS_READ : MS_WRITE;

   // ------------------------------------------------------------------
   // processor stepping and halted mode
   // ------------------------------------------------------------------
   assign wait_rise_w  = step_pend_q && cpu_wait_i && !cpu_wait_q;
   assign step_fin_w   = step_pend_q && cpu_step_done_i &&
                         !cpu_wait_i;
   assign erase_good_w = busy_q && erase_done_i && erase_ok_i;

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         halted_q    <= 1'b0;
         step_pend_q <= 1'b0;
         cpu_wait_q  <= 1'b0;
         mseq_q      <= MS_NONE;
      end else begin
         cpu_wait_q <= cpu_wait_i;
         mseq_q     <= mseq_d;
         if (is_step_w) begin
            step_pend_q <= 1'b1;
         end else if (step_fin_w) begin
            step_pend_q <= 1'b0;
         end
         if (is_go_w || is_step_w) begin
            halted_q <= 1'b0;
         end else if (is_bg_w || (cpu_bgnd_i && enable_q) ||
                      step_fin_w) begin
            halted_q <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // status flags
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ill_q    <= 1'b0;
         no_response_flag_q <= 1'b0;
         wait_q   <= 1'b0;
         enable_q <= 1'b0;
      end else begin
         // set wins over a clear in the same cycle
         ill_q    <= ill_w || (ill_q &&
                     !(wr_stat_w && cmd_wdata_i[8+HI_ILLEGAL]));
         no_response_flag_q <= step_wait_w || (no_response_flag_q &&
                     !(wr_stat_w && cmd_wdata_i[8+HI_NO_RESPONSE_FLAG]));
         wait_q   <= wait_rise_w || (wait_q &&
                     !(wr_stat_w && cmd_wdata_i[8+HI_WAIT]));
         if (wr_stat_w) begin
            enable_q <= cmd_wdata_i[LO_ENABLE];
         end
      end
   end

   // ------------------------------------------------------------------
   // security and mass erase
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         unsecured_flag_q         <= 1'b0;
         busy_q          <= 1'b0;
         erase_req_o     <= 1'b0;
         program_unsecured_flag_o <= 1'b0;
      end else begin
         erase_req_o     <= erase_w;
         program_unsecured_flag_o <= erase_good_w;
         if (start_w) begin
            unsecured_flag_q <= !secure_i;
         end else if (erase_good_w) begin
            unsecured_flag_q <= 1'b1;
         end
         if (erase_w) begin
            busy_q <= 1'b1;
         end else if (erase_done_i) begin
            busy_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // command outputs to processor and memory path
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cmd_exec_o    <= 1'b0;
         cmd_exec_op_o <= 8'h00;
         cpu_go_o      <= 1'b0;
         cpu_step_o    <= 1'b0;
         rd_wait_q     <= 1'b0;
         rd_size_q     <= 3'h4;
      end else begin
         cmd_exec_o <= mem_w;
         cpu_go_o   <= is_go_w;
         cpu_step_o <= is_step_w;
         if (mem_w) begin
            cmd_exec_op_o <= op_w;
         end
         if (mem_w && read_w) begin
            rd_wait_q <= 1'b1;
            rd_size_q <= dcs_nbytes(cmd_size_i);
         end else if (mem_rvalid_i) begin
            rd_wait_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // response serialiser
   // ------------------------------------------------------------------
   assign ld_stat_w = rd_stat_w;
   assign ld_fill_w = ill_w && read_w;
   assign ld_mem_w  = rd_wait_q && mem_rvalid_i;
   assign tx_load_w = ld_stat_w || ld_fill_w || ld_mem_w;

   assign ld_data_w = ld_stat_w ? {hi_w, lo_w, 16'h0000} :
                      ld_fill_w ? {4{FILL_BYTE}} :
                      (mem_rdata_i << {(3'h4 - rd_size_q), 3'h0});
   assign ld_n_w    = ld_stat_w ? 3'h2 :
                      ld_fill_w ? dcs_nbytes(cmd_size_i) : rd_size_q;

   assign low_cnt_w = tx_sh_q[31] ? ONE_CNT : ZERO_CNT;
   assign bit_end_w = (tx_cnt_q == 8'h01);

   always_comb begin
      tx_d = tx_q;
      case (tx_q)
         TX_IDLE: begin
            if (tx_load_w) begin
               tx_d = TX_LOW;
            end
         end
         TX_LOW: begin
            if (bit_end_w) begin
               tx_d = TX_HIGH;
            end
         end
         TX_HIGH: begin
            if (bit_end_w) begin
               tx_d = (tx_bits_q == 6'h01) ? TX_IDLE : TX_LOW;
            end
         end
         default: begin
            tx_d = TX_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_q      <= TX_IDLE;
         tx_sh_q   <= 32'h0000_0000;
         tx_bits_q <= 6'h00;
         tx_cnt_q  <= 8'h00;
      end else begin
         tx_q <= tx_d;
         if ((tx_q == TX_IDLE) && tx_load_w) begin
            tx_sh_q   <= ld_data_w;
            tx_bits_q <= {ld_n_w, 3'h0};
            tx_cnt_q  <= ld_data_w[31] ? ONE_CNT : ZERO_CNT;
         end else if ((tx_q == TX_LOW) && bit_end_w) begin
            tx_cnt_q <= BIT_CNT - low_cnt_w;
         end else if ((tx_q == TX_HIGH) && bit_end_w) begin
            tx_sh_q   <= {tx_sh_q[30:0], 1'b0};
            tx_bits_q <= tx_bits_q - 6'h01;
            tx_cnt_q  <= tx_sh_q[30] ? ONE_CNT : ZERO_CNT;
         end else if (tx_q != TX_IDLE) begin
            tx_cnt_q <= tx_cnt_q - 8'h01;
         end
      end
   end

   dcs_pin_drv u_drv (
      .sys_clk_i  (sys_clk_i),
      .arst_n_i   (arst_n_i),
      .pull_low_i (tx_q == TX_LOW),
      .pin_o      (dbg_wire_pin_o),
      .pin_oe_o   (dbg_wire_pin_oe_o)
   );

   // ------------------------------------------------------------------
   // status bytes and level outputs
   // ------------------------------------------------------------------
   assign hi_w = {2'b00, halted_q, busy_q, unsecured_flag_q, wait_q, no_response_flag_q, ill_q};
   assign lo_w = STATUS_RST | {enable_q, 7'h00};

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ready_o     <= 1'b0;
         tx_busy_o   <= 1'b0;
         cpu_halt_o  <= 1'b0;
         status_hi_o <= STATUS_RST;
         status_lo_o <= STATUS_RST;
      end else begin
         ready_o     <= ready_q;
         tx_busy_o   <= (tx_d != TX_IDLE) || rd_wait_q;
         cpu_halt_o  <= halted_q;
         status_hi_o <= hi_w;
         status_lo_o <= lo_w;
      end
   end

endmodule

/* test/dcs_debug_ctrl_monitor.sv */
// assertions on the debug command/status block ports
`timescale 1ns/100ps
module dcs_debug_ctrl_monitor (
   input wire logic        sys_clk_i,
   input wire logic        arst_n_i,
   input wire logic        dbg_wire_pin_o,
   input wire logic        dbg_wire_pin_oe_o,
   input wire logic        cmd_valid_i,
   input wire logic [7:0]  cmd_opcode_i,
   input wire logic [15:0] cmd_wdata_i,
   input wire logic        cpu_wait_i,
   input wire logic        erase_done_i,
   input wire logic        erase_ok_i,
   input wire logic        ready_o,
   input wire logic        tx_busy_o,
   input wire logic        cpu_step_o,
   input wire logic        program_unsecured_flag_o,
   input wire logic [7:0]  status_hi_o
);
   import dcs_pkg::*;
   logic [3:0] cyc_q;
   wire tk  = cmd_valid_i & ready_o & ~tx_busy_o;
   wire clr = tk && cmd_opcode_i == OP_WRITE_STATUS && cmd_wdata_i[8];
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!arst_n_i);
   // ------------------------------------------------------------------
   // cycles since reset release, saturating
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i)
         cyc_q <= 4'h0;
      else if (cyc_q != 4'hf)
         cyc_q <= cyc_q + 4'h1;
   end
   property p_ready;
      $rose(ready_o) |-> cyc_q inside {4'ha, 4'hb};
   endproperty
   property p_illop;
      tk && cmd_opcode_i == 8'hff |-> ##2 status_hi_o[HI_ILLEGAL];
   endproperty
   property p_sticky;
      $fell(status_hi_o[HI_ILLEGAL]) |-> $past(clr, 2);
   endproperty
   property p_speedup;
      dbg_wire_pin_oe_o && dbg_wire_pin_o |=> !dbg_wire_pin_oe_o;
   endproperty
   property p_wait;
      cpu_step_o ##[1:8] $rose(cpu_wait_i) |-> ##[1:2] status_hi_o[HI_WAIT];
   endproperty
   property p_no_response_flag;
      tk && cmd_opcode_i == OP_SINGLE_STEP_COMMAND && cpu_wait_i && status_hi_o[HI_WAIT]
         |-> ##2 status_hi_o[1:0] == 2'b11;
   endproperty
   property p_good;
      erase_done_i && erase_ok_i && status_hi_o[HI_ERASE]
         |=> program_unsecured_flag_o ##[0:2] status_hi_o[HI_UNSECURED_FLAG];
   endproperty
   property p_bad;
      erase_done_i && !erase_ok_i && status_hi_o[HI_ERASE] &&
         !status_hi_o[HI_UNSECURED_FLAG]
         |=> (!program_unsecured_flag_o && !status_hi_o[HI_UNSECURED_FLAG]) [*3];
   endproperty
   a_ready:   assert property (p_ready)   else $error("late ready");
   a_illop:   assert property (p_illop)   else $error("no flag");
   a_sticky:  assert property (p_sticky)  else $error("flag lost");
   a_speedup: assert property (p_speedup) else $error("long pulse");
   a_wait:    assert property (p_wait)    else $error("no wait");
   a_no_response_flag:  assert property (p_no_response_flag)  else $error("no no_response_flag");
   a_good:    assert property (p_good)    else $error("no unsecured_flag");
   a_bad:     assert property (p_bad)     else $error("bad unsecured_flag");
   c_erase: cover property (program_unsecured_flag_o);
   c_step:  cover property (cpu_step_o);
   c_clr:   cover property ($fell(status_hi_o[HI_ILLEGAL]));
endmodule

bind dcs_debug_ctrl dcs_debug_ctrl_monitor u_mon (.*);

/* test/dcs_host_model.sv */
// host side of the debug wire: pull-up, mode strap, response decode
`timescale 1ns/100ps
module dcs_host_model (
   input  wire logic       sys_clk_i,
   input  wire logic       arst_n_i,
   input  wire logic       strap_low_i,
   input  wire logic       dev_o_i,
   input  wire logic       dev_oe_i,
   output logic            wire_o,
   output logic [7:0]      byte_o,
   output logic            byte_vld_o
);
   logic [4:0] low_q;
   logic [2:0] bit_q;
   // device drive wins, else strap low or pull-up
   assign wire_o = dev_oe_i ? dev_o_i : !strap_low_i;
   // long low phase is a zero, msb first
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         low_q <= 5'h0;
         bit_q <= 3'h0;
         byte_o <= 8'h00;
         byte_vld_o <= 1'b0;
      end else begin
         byte_vld_o <= 1'b0;
         if (!wire_o && !strap_low_i)
            low_q <= low_q + 5'h1;
         else if (low_q != 5'h0) begin
            byte_o <= {byte_o[6:0], low_q < 5'h9};
            bit_q <= bit_q + 3'h1;
            byte_vld_o <= (bit_q == 3'h7);
            low_q <= 5'h0;
         end
      end
   end
endmodule

/* test/dcs_debug_ctrl_tb.sv */
// self-checking bench for the debug command/status block
`timescale 1ns/100ps
module dcs_debug_ctrl_tb;
   import dcs_pkg::*;
   logic        sys_clk_i = 1'b0;
   logic        arst_n_i = 1'b0;
   logic        strap = 1'b1;
   logic        cmd_valid_i = 1'b0;
   logic        cpu_wait_i = 1'b0;
   logic        done = 1'b0;
   logic        erase_done_i = 1'b0;
   logic        erase_ok_i = 1'b0;
   logic [7:0]  cmd_opcode_i = 8'h00;
   logic [15:0] cmd_wdata_i = 16'h0000;
   logic [2:0]  cmd_size_i = 3'h1;
   logic [2:0]  sz;
   logic [31:0] rdata = 32'h0;
   logic        pin_o, pin_oe, lvl, msel, ready, busy, bvld;
   logic [7:0]  rbyte;
   logic [7:0]  exp_q[$];
   int          fail_count = 0;
   int          comparisons = 0;
   always #25 sys_clk_i = ~sys_clk_i;
   dcs_debug_ctrl DUT (.sys_clk_i, .arst_n_i, .dbg_wire_pin_i(lvl),
      .dbg_wire_pin_o(pin_o), .dbg_wire_pin_oe_o(pin_oe), .cmd_valid_i,
      .cmd_opcode_i, .cmd_wdata_i, .cmd_size_i, .mem_rvalid_i(1'b0),
      .mem_rdata_i(rdata), .cpu_bgnd_i(1'b0), .cpu_wait_i,
      .cpu_step_done_i(done), .secure_i(1'b1), .erase_done_i, .erase_ok_i,
      .ready_o(ready), .mode_select_o(msel), .dbg_rx_o(), .tx_busy_o(busy),
      .cmd_exec_o(), .cmd_exec_op_o(), .cpu_halt_o(), .cpu_go_o(),
      .cpu_step_o(), .erase_req_o(), .program_unsecured_flag_o(), .status_hi_o(),
      .status_lo_o());
   dcs_host_model HOST (.sys_clk_i, .arst_n_i, .strap_low_i(strap),
      .dev_o_i(pin_o), .dev_oe_i(pin_oe), .wire_o(lvl), .byte_o(rbyte),
      .byte_vld_o(bvld));
   task automatic chk(input logic [7:0] got, exp, input string nm);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic cmd(input logic [7:0] op, input logic [15:0] wd = 16'h0,
                      input logic [2:0] n = 3'h1);
      do @(negedge sys_clk_i); while (ready !== 1'b1 || busy !== 1'b0);
      @(posedge sys_clk_i);
      cmd_opcode_i <= op;
      cmd_wdata_i <= wd;
      cmd_size_i <= n;
      cmd_valid_i <= 1'b1;
      @(posedge sys_clk_i);
      cmd_valid_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
   endtask
   task automatic rd(input logic [7:0] h, input logic [7:0] l);
      exp_q.push_back(h);
      exp_q.push_back(l);
      cmd(OP_READ_STATUS, 16'h0, 3'h2);
   endtask
   task automatic erase(input logic ok);
      cmd(OP_ERASE_FLASH);
      erase_ok_i <= ok;
      erase_done_i <= 1'b1;
      @(posedge sys_clk_i);
      erase_done_i <= 1'b0;
   endtask
   // ------------------------------------------------------------------
   // response watcher and watchdog
   // ------------------------------------------------------------------
   always @(negedge sys_clk_i) begin
      if (bvld === 1'b1)
         chk(rbyte, exp_q.size() ? exp_q.pop_front() : ~rbyte, "rx");
   end
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      fail_count++;
      end_of_test();
   end
   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      void'($urandom(32'ha295));
      sz = 3'($urandom_range(4, 1));
      repeat (2) @(posedge sys_clk_i);
      rdata <= $urandom();
      arst_n_i <= 1'b1;
      do @(negedge sys_clk_i); while (ready !== 1'b1);
      chk({7'h0, msel}, 8'h00, "msel");
      @(posedge sys_clk_i);
      strap <= 1'b0;
      repeat (sz) exp_q.push_back(8'hee);
      cmd(OP_READ_MEM, 16'h0, sz);
      cmd(8'hff);
      cmd(OP_WRITE_STATUS, 16'h0000);
      rd(8'h01, 8'h00);
      cmd(OP_WRITE_STATUS, 16'h0100);
      rd(8'h00, 8'h00);
      erase(1'b0);
      rd(8'h00, 8'h00);
      erase(1'b1);
      rd(8'h08, 8'h00);
      cmd(OP_WRITE_STATUS, 16'h0080);
      cmd(OP_BACKGROUND);
      exp_q.push_back(8'hee);
      cmd(OP_DUMP_MEM);
      cmd(OP_SINGLE_STEP_COMMAND);
      cpu_wait_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      cmd(OP_SINGLE_STEP_COMMAND);
      rd(8'h0f, 8'h80);
      done <= 1'b1;
      rd(8'h0f, 8'h80);
      cpu_wait_i <= 1'b0;
      @(posedge sys_clk_i);
      done <= 1'b0;
      cmd(OP_WRITE_STATUS, 16'h0780);
      rd(8'h28, 8'h80);
      do @(negedge sys_clk_i); while (exp_q.size() != 0 || busy !== 1'b0);
      end_of_test();
   end
endmodule
